// [acs_axil_slave.sv]
// axi4-lite slave front end of the register file
`timescale 1ns/1ps
module acs_axil_slave (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   acs_reg_if.slv           rif
);
   import acs_pkg::*;

   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;

   wire do_wr = aw_held && w_held && !s_axi_bvalid;
   wire ar_go = s_axi_arvalid && s_axi_arready;

   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign s_axi_arready = !s_axi_rvalid;
   assign rif.wr_en     = do_wr;
   assign rif.wr_addr   = aw_addr_q;
   assign rif.wr_data   = w_data_q;
   assign rif.wr_strb   = w_strb_q;
   assign rif.rd_addr   = s_axi_araddr;

   // =====================================================================
   // write and read channels
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr_q    <= '0;
         w_data_q     <= '0;
         w_strb_q     <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held   <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (do_wr) aw_held <= 1'b0;
         if (s_axi_wvalid && !w_held) begin
            w_held   <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (do_wr) w_held <= 1'b0;
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
         if (ar_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rif.rd_data;
            s_axi_rresp  <= rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// [acs_clock_selector.sv]
// audio clock source selector: input monitors, reference choice, frame clock
// Function
// - master crystal mode or automatic reference mode
// - unavailable preferred reference moves to next
// - candidates: optical, serial, word clock, sync port
// - scan inputs, adopt valid one matching playback rate (optical at half in split)
// - keep valid preferred, else first valid in turn
// - no valid input falls back to master
// - report master or slave clock state
// - report active reference and its measured rate
// - per input: no lock, lock or sync
// - all inputs monitored at once, one reference
// - lock to any rate within supported range
// - double rate with optical preferred enters split
// - split mode reports optical rate as half serial
// - serial input from coax or first optical
// - serial output always coax, optionally optical
// - serial input rate is separate status value
// - buffer length power of two, 64 to 4096
`timescale 1ns/1ps
module acs_clock_selector #(
   parameter int PER_MAX = acs_pkg::PER_MAX_CYC
) (
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic [2:0]           opt_fclk,
   input  wire logic                 ser_coax_fclk,
   input  wire logic                 ser_opt_fclk,
   input  wire logic                 word_clk_in,
   input  wire logic                 sync_port_input,
   input  wire logic                 ser_coax_rx,
   input  wire logic                 first_optical_port_rx,
   input  wire logic                 ser_tx_data,
   input  wire logic                 opt_tx_data,
   output logic                      ser_coax_tx,
   output logic                      first_optical_port_tx,
   output logic                      ser_rx_data,
   output logic                      sys_frame_tick,
   output logic                      split_mode,
   output acs_pkg::acs_clk_e         clock_state,
   output acs_pkg::acs_src_t         active_reference_status,
   output logic [11:0]               input_lock_monitor,
   output logic [acs_pkg::BUF_W-1:0] dma_buf_len
);
   import acs_pkg::*;

   // =====================================================================
   // bus slave
   acs_reg_if rif ();

   acs_axil_slave u_axil (
      .sys_clk       (sys_clk),
      .reset_n       (reset_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .rif           (rif.slv)
   );

   // =====================================================================
   // pin synchronisers
   logic [N_PIN-1:0] pin_raw;
   logic [N_PIN-1:0] pin_s1;
   logic [N_PIN-1:0] pin_s2;

   assign pin_raw = {first_optical_port_rx, ser_coax_rx, sync_port_input,
                     word_clk_in, ser_opt_fclk, ser_coax_fclk, opt_fclk};

   genvar gp;
   generate
      for (gp = 0; gp < N_PIN; gp++) begin : g_sync
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               pin_s1[gp] <= 1'b0;
               pin_s2[gp] <= 1'b0;
            end else begin
               pin_s1[gp] <= pin_raw[gp];
               pin_s2[gp] <= pin_s1[gp];
            end
         end
      end
   endgenerate

   // =====================================================================
   // control registers
   logic [31:0] ctrl;
   acs_per_t    play_per;

   wire       auto_mode  = ctrl[CTRL_AUTO];
   wire [2:0] pref_raw   = ctrl[CTRL_PREF_LSB +: 3];
   wire       ser_opt    = ctrl[CTRL_SER_OPT];
   wire       out_opt    = ctrl[CTRL_OUT_OPT];
   wire       rate_chk   = ctrl[CTRL_RATE_CHK];
   wire [2:0] buf_raw    = ctrl[CTRL_BUF_LSB +: 3];
   wire [2:0] pref       = (pref_raw >= 3'(N_SRC)) ? 3'h0 : pref_raw;
   wire [2:0] buf_code   = (buf_raw > BUF_CODE_MAX) ? BUF_CODE_MAX : buf_raw;
   wire       wr_ctrl    = rif.wr_en && rif.wr_addr == REG_CTRL;
   wire       wr_play    = rif.wr_en && rif.wr_addr == REG_PLAY;
   wire [31:0] play_word = acs_wmask({16'h0000, play_per}, rif.wr_data,
                                     rif.wr_strb);

   assign rif.wr_hit = rif.wr_addr == REG_CTRL || rif.wr_addr == REG_PLAY;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl     <= CTRL_RST;
         play_per <= acs_per_t'(PLAY_PER_CYC);
      end else begin
         if (wr_ctrl) ctrl <= acs_wmask(ctrl, rif.wr_data, rif.wr_strb);
         if (wr_play) play_per <= play_word[PER_W-1:0];
      end
   end

   // =====================================================================
   // input monitors, all running in parallel
   logic                  frame_tick;
   logic [N_SRC-1:0]      src_lvl;
   logic [N_SRC-1:0]      src_edge;
   acs_per_t              src_per   [N_SRC];
   acs_per_t              src_rep   [N_SRC];
   acs_lock_e             src_lock  [N_SRC];
   logic [N_SRC-1:0]      src_valid;

   wire ser_lvl = ser_opt ? pin_s2[PIN_OPT_FCLK]
                          : pin_s2[PIN_COAX_FCLK];
   assign src_lvl = {pin_s2[PIN_SYNC], pin_s2[PIN_WORD], ser_lvl,
                     pin_s2[N_OPT-1:0]};

   // double rate playback with optical preferred runs split
   assign split_mode = auto_mode && pref < 3'(N_OPT) &&
                       play_per <= acs_per_t'(DBL_PER_CYC);

   genvar gs;
   generate
      for (gs = 0; gs < N_SRC; gs++) begin : g_src
         wire      is_opt = gs < N_OPT;
         wire acs_per_t want = (split_mode && is_opt) ? {play_per[PER_W-2:0],
                                                         1'b0} : play_per;
         acs_rate_meter #(
            .PER_MAX (PER_MAX)
         ) u_meter (
            .sys_clk    (sys_clk),
            .reset_n    (reset_n),
            .fclk_lvl   (src_lvl[gs]),
            .frame_tick (frame_tick),
            .edge_seen  (src_edge[gs]),
            .period     (src_per[gs]),
            .lock_state (src_lock[gs])
         );
         assign src_rep[gs] = (split_mode && is_opt) ?
                              {src_per[SRC_SER][PER_W-2:0], 1'b0} : src_per[gs];
         // valid signal at the playback rate (half of it for optical in split), or any rate when unchecked
         assign src_valid[gs] = src_lock[gs] != LK_NONE &&
                                (!rate_chk || acs_absdiff(src_per[gs], want)
                                 <= acs_per_t'(PER_TOL));
         assign input_lock_monitor[2*gs +: 2] = src_lock[gs];
      end
   endgenerate

   // =====================================================================
   // reference choice
   acs_src_t next_ref;

   always_comb begin
      logic found;
      int   idx;
      found    = 1'b0;
      idx      = 0;
      next_ref = SRC_INTERNAL;
      if (auto_mode) begin
         // preferred first, then the others in turn
         for (int k = 0; k < N_SRC; k++) begin
            idx = (int'(pref) + k) % N_SRC;
            if (!found && src_valid[idx]) begin
               next_ref = acs_src_t'(idx);
               found    = 1'b1;
            end
         end
      end
   end

   // =====================================================================
   // frame clock generation and switch commit
   acs_per_t div_cnt;
   acs_per_t gap_cnt;
   acs_per_t half_cnt;
   logic     mid_armed;

   wire           is_slave    = clock_state == CLK_SLAVE;
   wire           ref_edge    = is_slave &&
                                src_edge[active_reference_status];
   wire acs_per_t ref_per     = src_per[active_reference_status];
   wire           master_tick = div_cnt >= play_per - acs_per_t'(1);
   wire           ref_opt     = active_reference_status < 3'(N_OPT);
   wire           mid_tick    = split_mode && ref_opt && mid_armed &&
                                half_cnt >= {1'b0, ref_per[PER_W-1:1]};
   wire           stalled     = is_slave && gap_cnt >= acs_per_t'(PER_MAX);
   wire           commit      = frame_tick || stalled;

   assign frame_tick = is_slave ? (ref_edge || mid_tick) : master_tick;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt   <= '0;
         gap_cnt   <= '0;
         half_cnt  <= '0;
         mid_armed <= 1'b0;
      end else begin
         if (master_tick || ref_edge) div_cnt <= '0;
         else div_cnt <= div_cnt + acs_per_t'(1);
         if (frame_tick) gap_cnt <= '0;
         else if (!stalled) gap_cnt <= gap_cnt + acs_per_t'(1);
         if (ref_edge) begin
            half_cnt  <= '0;
            mid_armed <= 1'b1;
         end else begin
            if (half_cnt != '1) half_cnt <= half_cnt + acs_per_t'(1);
            if (mid_tick) mid_armed <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         active_reference_status <= SRC_INTERNAL;
         clock_state             <= CLK_MASTER;
      end else if (commit) begin
         active_reference_status <= next_ref;
         clock_state <= (next_ref == SRC_INTERNAL) ? CLK_MASTER
                                                   : CLK_SLAVE;
      end
   end

   // =====================================================================
   // serial data routing, frame tick and buffer length outputs
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ser_coax_tx           <= 1'b0;
         first_optical_port_tx <= 1'b0;
         ser_rx_data           <= 1'b0;
         sys_frame_tick        <= 1'b0;
         dma_buf_len           <= '0;
      end else begin
         ser_coax_tx           <= ser_tx_data;
         first_optical_port_tx <= out_opt ? ser_tx_data : opt_tx_data;
         ser_rx_data           <= ser_opt ? pin_s2[PIN_OPT_RX]
                                          : pin_s2[PIN_COAX_RX];
         sys_frame_tick        <= frame_tick;
         dma_buf_len           <= BUF_W'(BUF_MIN_LEN) << buf_code;
      end
   end

   // =====================================================================
   // read decode
   acs_per_t    act_per;
   logic [31:0] stat_word;
   logic [2:0]  rd_src;

   assign act_per   = is_slave ? src_rep[active_reference_status] : play_per;
   assign stat_word = {4'h0, input_lock_monitor, 11'h000, split_mode,
                       clock_state, active_reference_status};
   assign rd_src    = rif.rd_addr[4:2];

   wire rd_is_ctrl = rif.rd_addr == REG_CTRL;
   wire rd_is_play = rif.rd_addr == REG_PLAY;
   wire rd_is_stat = rif.rd_addr == REG_STAT;
   wire rd_is_act  = rif.rd_addr == REG_ACT_PER;
   wire rd_is_ser  = rif.rd_addr == REG_SER_PER;
   wire rd_is_buf  = rif.rd_addr == REG_BUF;
   wire rd_is_src  = rif.rd_addr[7:5] == REG_SRC_PAGE &&
                     rif.rd_addr[1:0] == 2'b00 && rd_src < 3'(N_SRC);

   assign rif.rd_hit  = rd_is_ctrl || rd_is_play || rd_is_stat || rd_is_act ||
                        rd_is_ser || rd_is_buf || rd_is_src;
   assign rif.rd_data = rd_is_ctrl ? ctrl :
                        rd_is_play ? {16'h0000, play_per} :
                        rd_is_stat ? stat_word :
                        rd_is_act  ? {16'h0000, act_per} :
                        rd_is_ser  ? {16'h0000, src_per[SRC_SER]} :
                        rd_is_buf  ? {19'h00000, dma_buf_len} :
                        rd_is_src  ? {16'h0000, src_rep[rd_src]} :
                        32'h0000_0000;

endmodule

// [acs_clock_selector_checker.sv]
// port assertions of the clock selector
`timescale 1ns/1ps
module acs_clock_selector_checker #(parameter int PER_MAX = 10000) (
   input wire logic              sys_clk,
   input wire logic              reset_n,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              ser_tx_data,
   input wire logic              ser_coax_tx,
   input wire logic              sys_frame_tick,
   input wire acs_pkg::acs_clk_e clock_state,
   input wire acs_pkg::acs_src_t active_reference_status,
   input wire logic [11:0]       input_lock_monitor,
   input wire logic [12:0]       dma_buf_len
);
   import acs_pkg::*;
   // ====
   // checks
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire lk_bad = |(input_lock_monitor & (input_lock_monitor >> 1) & 12'h555);
   sequence no_tick; !sys_frame_tick [*8]; endsequence
   a_coax_delay: assert property ($past(reset_n) |->
      ser_coax_tx == $past(ser_tx_data)) else $error("coax late");
   a_slave_ref: assert property (clock_state == CLK_SLAVE |->
      active_reference_status < 6) else $error("slave no ref");
   a_master_int: assert property (clock_state == CLK_MASTER |->
      active_reference_status == SRC_INTERNAL) else $error("master ref");
   a_lock_legal: assert property (!lk_bad) else $error("lock code");
   a_buf_pow2: assert property ($past(reset_n) |->
      $onehot(dma_buf_len) && dma_buf_len inside {[64:4096]})
      else $error("buf len");
   a_tick_gap: assert property (sys_frame_tick |=> no_tick)
      else $error("tick gap");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("b drop");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("r drop");
endmodule
bind acs_clock_selector acs_clock_selector_checker #(.PER_MAX(PER_MAX)) u_chk (.*);

// [acs_clock_selector_test.sv]
// bench for the audio clock source selector
`timescale 1ns/1ps
module acs_clock_selector_test;
   import acs_pkg::*;
   logic        sys_clk = 0, reset_n = 0, en = 0, q = 0, fc, ta, tw, tb;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid;
   logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
   logic        ser_tx_data = 0, opt_tx_data = 0, ser_coax_tx, split_mode;
   logic        first_optical_port_tx, sys_frame_tick;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [11:0] input_lock_monitor;
   logic [12:0] dma_buf_len;
   acs_clk_e    clock_state;
   acs_src_t    active_reference_status;
   int          fails = 0, total_checks = 0;
   acs_frame_src u_acs_frame_src (.en(en), .fclk(fc));
   acs_clock_selector u_acs_clock_selector (.opt_fclk({q, fc, q}),
      .ser_coax_fclk(q), .ser_opt_fclk(q), .word_clk_in(fc),
      .sync_port_input(q), .ser_coax_rx(fc), .first_optical_port_rx(fc),
      .ser_rx_data(), .*);
   always #2 sys_clk = ~sys_clk;
   // ====
   // tasks
   task automatic chk(input string n, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test();
      if (fails == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      do begin
         @(negedge sys_clk);
         ta = s_axi_awready & s_axi_awvalid | s_axi_arready & s_axi_arvalid;
         tw = s_axi_wready & s_axi_wvalid;
         tb = s_axi_bvalid | s_axi_rvalid;
         {d, r} = {s_axi_rdata, s_axi_rresp};
         @(posedge sys_clk);
         if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
         if (tw) s_axi_wvalid <= 0;
         if (tb) {s_axi_bready, s_axi_rready} <= 2'h0;
      end while (!tb);
      @(negedge sys_clk);
   endtask
   task automatic wait_st(input acs_clk_e c);
      for (int i = 0; i < 40000 && clock_state !== c; i++) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   // ====
   // tests
   initial begin
      #320000;
      fails++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1;
      bus(0, REG_CTRL, 0);
      chk("ctrl", d, CTRL_RST);
      chk("ref", active_reference_status, SRC_INTERNAL);
      for (int c = 0; c < 8; c++) begin
         bus(1, REG_CTRL, 32'h60 | (c << 8));
         chk("buf", dma_buf_len, 64 << (c > 6 ? 6 : c));
      end
      @(posedge sys_clk) ser_tx_data <= 1;
      repeat (2) @(negedge sys_clk);
      chk("coax", ser_coax_tx, 1);
      chk("opt", first_optical_port_tx, 1);
      bus(0, 8'h18, 0);
      chk("resp", r, RESP_SLVERR);
      @(posedge sys_clk) en <= 1;
      bus(1, REG_CTRL, 32'h41);
      chk("opt", first_optical_port_tx, 0);
      wait_st(CLK_SLAVE);
      chk("state", clock_state, CLK_SLAVE);
      chk("ref", active_reference_status, 3'h1);
      chk("lock", input_lock_monitor[1:0], LK_NONE);
      bus(0, REG_STAT, 0);
      chk("stat", d[3:0], 4'h9);
      @(posedge sys_clk) en <= 0;
      wait_st(CLK_MASTER);
      chk("ref", active_reference_status, SRC_INTERNAL);
      bus(1, REG_PLAY, 2604);
      chk("split", split_mode, 1);
      bus(0, REG_ACT_PER, 0);
      chk("act", d, 2604);
      finish_test();
   end
endmodule

// [acs_frame_src.sv]
// external frame clock source, idles low
`timescale 1ns/1ps
module acs_frame_src (
   input wire logic en,
   output logic     fclk
);
   // ====
   // 5208-cycle frame, held low when off
   initial fclk = 0;
   always #10416 fclk = en & !fclk;
endmodule

// [acs_pkg.sv]
// constants, types and helpers of the audio clock source selector
package acs_pkg;

   // =====================================================================
   // clock and rate limits
   localparam int SYS_CLK_HZ     = 250_000_000;
   localparam int FS_MIN_HZ      = 25_000;
   localparam int FS_MAX_HZ      = 105_000;
   localparam int DBL_MIN_HZ     = 88_200;
   localparam int PLAY_RST_HZ    = 48_000;
   localparam int PER_MAX_CYC    = SYS_CLK_HZ / FS_MIN_HZ;
   localparam int PER_MIN_CYC    = (SYS_CLK_HZ + FS_MAX_HZ - 1) / FS_MAX_HZ;
   localparam int DBL_PER_CYC    = SYS_CLK_HZ / DBL_MIN_HZ;
   localparam int PLAY_PER_CYC   = SYS_CLK_HZ / PLAY_RST_HZ;
   localparam int PER_W          = 16;
   localparam int PER_TOL        = 4;
   localparam int PHASE_TOL      = 8;

   typedef logic [PER_W-1:0] acs_per_t;

   // =====================================================================
   // sources, lock states, clock states
   localparam int N_SRC  = 6;
   localparam int N_OPT  = 3;
   localparam int N_PIN  = 9;
   typedef logic [2:0] acs_src_t;
   localparam acs_src_t SRC_SER      = 3'h3;
   localparam acs_src_t SRC_INTERNAL = 3'h7;
   localparam int PIN_COAX_FCLK = 3;
   localparam int PIN_OPT_FCLK  = 4;
   localparam int PIN_WORD      = 5;
   localparam int PIN_SYNC      = 6;
   localparam int PIN_COAX_RX   = 7;
   localparam int PIN_OPT_RX    = 8;

   typedef enum logic [1:0] {
      LK_NONE = 2'b00,
      LK_LOCK = 2'b01,
      LK_SYNC = 2'b10
   } acs_lock_e;

   typedef enum logic {
      CLK_MASTER = 1'b0,
      CLK_SLAVE  = 1'b1
   } acs_clk_e;

   // =====================================================================
   // register map
   localparam int AW = 8;
   localparam logic [AW-1:0] REG_CTRL     = 8'h00;
   localparam logic [AW-1:0] REG_PLAY     = 8'h04;
   localparam logic [AW-1:0] REG_STAT     = 8'h08;
   localparam logic [AW-1:0] REG_ACT_PER  = 8'h0c;
   localparam logic [AW-1:0] REG_SER_PER  = 8'h10;
   localparam logic [AW-1:0] REG_BUF      = 8'h14;
   localparam logic [2:0]    REG_SRC_PAGE = 3'h1;
   localparam int CTRL_AUTO     = 0;
   localparam int CTRL_PREF_LSB = 1;
   localparam int CTRL_SER_OPT  = 4;
   localparam int CTRL_OUT_OPT  = 5;
   localparam int CTRL_RATE_CHK = 6;
   localparam int CTRL_BUF_LSB  = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0340;
   localparam int STAT_SLAVE    = 3;
   localparam int STAT_SPLIT    = 4;
   localparam int STAT_LK_LSB   = 16;
   localparam int BUF_W         = 13;
   localparam int BUF_MIN_LEN   = 64;
   localparam logic [2:0] BUF_CODE_MAX = 3'h6;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   function automatic acs_per_t acs_absdiff(acs_per_t a, acs_per_t b);
      return (a > b) ? a - b : b - a;
   endfunction

   function automatic logic [31:0] acs_wmask(logic [31:0] o, logic [31:0] n,
                                             logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[8*i +: 8] = n[8*i +: 8];
      end
      return r;
   endfunction

endpackage

// [acs_rate_meter.sv]
// frame period, lock and phase monitor for one synchronised frame clock
`timescale 1ns/1ps
module acs_rate_meter #(
   parameter int PER_MAX = acs_pkg::PER_MAX_CYC
) (
   input  wire logic          sys_clk,
   input  wire logic          reset_n,
   input  wire logic          fclk_lvl,
   input  wire logic          frame_tick,
   output logic               edge_seen,
   output acs_pkg::acs_per_t  period,
   output acs_pkg::acs_lock_e lock_state
);
   import acs_pkg::*;

   logic     fclk_d;
   logic     locked;
   logic     synced;
   acs_per_t cnt;
   acs_per_t phase_cnt;
   acs_per_t phase_last;

   wire           rise     = fclk_lvl & ~fclk_d;
   wire acs_per_t meas     = cnt + acs_per_t'(1);
   wire           stale    = cnt >= acs_per_t'(PER_MAX);
   wire           in_range = meas >= acs_per_t'(PER_MIN_CYC) &&
                             meas <= acs_per_t'(PER_MAX);
   wire           steady   = acs_absdiff(meas, period) <= acs_per_t'(PER_TOL);
   wire           aligned  = acs_absdiff(phase_cnt, phase_last) <=
                             acs_per_t'(PHASE_TOL);

   // =====================================================================
   // period, lock and phase tracking
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fclk_d     <= 1'b0;
         edge_seen  <= 1'b0;
         cnt        <= '0;
         period     <= '0;
         locked     <= 1'b0;
         synced     <= 1'b0;
         phase_cnt  <= '0;
         phase_last <= '0;
      end else begin
         fclk_d    <= fclk_lvl;
         edge_seen <= rise;
         if (rise) begin
            cnt        <= '0;
            period     <= meas;
            locked     <= in_range && steady;
            synced     <= in_range && steady && locked && aligned;
            phase_last <= phase_cnt;
         end else if (!stale) begin
            cnt <= cnt + acs_per_t'(1);
         end else begin
            locked <= 1'b0;
            synced <= 1'b0;
         end
         if (frame_tick) phase_cnt <= '0;
         else if (phase_cnt != '1) phase_cnt <= phase_cnt + acs_per_t'(1);
      end
   end

   assign lock_state = synced ? LK_SYNC : (locked ? LK_LOCK : LK_NONE);

endmodule

// [acs_reg_if.sv]
// register access carrier between bus slave and register file
`timescale 1ns/1ps
interface acs_reg_if;
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_hit;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_hit;
   modport slv  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input wr_hit, rd_data, rd_hit);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_hit, rd_data, rd_hit);
endinterface
